// ---- rtl/cis_defines.svh ----
// constants for the cpu instruction subset core
`ifndef CIS_DEFINES_SVH
`define CIS_DEFINES_SVH

`define CIS_OP_SUB_IMMED 8'hA0
`define CIS_OP_SUB_DIR 8'hB0
`define CIS_OP_SUB_LONG 8'hC0
`define CIS_OP_SUB_OFF16 8'hD0
`define CIS_OP_SUB_OFF8 8'hE0
`define CIS_OP_SUB_IX 8'hF0
`define CIS_OP_TZN_DIR 8'h3D
`define CIS_OP_TZN_A 8'h4D
`define CIS_OP_TZN_X 8'h5D
`define CIS_OP_TZN_OFF8 8'h6D
`define CIS_OP_TZN_IX 8'h7D
`define CIS_OP_SOFTINT 8'h83
`define CIS_OP_A2X 8'h97
`define CIS_OP_X2A 8'h9F
`define CIS_OP_WAIT 8'h8F

`define CIS_CYC_SUB_IMMED 4'd2
`define CIS_CYC_SUB_DIR 4'd3
`define CIS_CYC_SUB_LONG 4'd4
`define CIS_CYC_SUB_OFF16 4'd5
`define CIS_CYC_SUB_OFF8 4'd4
`define CIS_CYC_SUB_IX 4'd3
`define CIS_CYC_TZN_DIR 4'd4
`define CIS_CYC_TZN_REG 4'd3
`define CIS_CYC_TZN_OFF8 4'd5
`define CIS_CYC_TZN_IX 4'd4
`define CIS_CYC_SOFTINT 4'd10
`define CIS_CYC_XFER 4'd2
`define CIS_CYC_WAIT 4'd2
`define CIS_CYC_NOP 4'd2

`define CIS_STEP_FETCH 4'd0
`define CIS_STEP_OPND1 4'd1
`define CIS_SOFTINT_PUSH_PCL 4'd2
`define CIS_SOFTINT_PUSH_PCH 4'd3
`define CIS_SOFTINT_PUSH_X 4'd4
`define CIS_SOFTINT_PUSH_A 4'd5
`define CIS_SOFTINT_PUSH_FLAGS 4'd6
`define CIS_SOFTINT_MASK 4'd7
`define CIS_SOFTINT_VEC_HI 4'd8
`define CIS_SOFTINT_VEC_LO 4'd9

`define CIS_FLAG_C 0
`define CIS_FLAG_Z 1
`define CIS_FLAG_N 2
`define CIS_FLAG_I 3
`define CIS_FLAG_RST 8'hE8
`define CIS_SP_RST 8'hFF
`define CIS_PC_RST 16'h0100
`define CIS_SOFTINT_VEC 16'hFFFC
`define CIS_SOFTINT_VEC_LOW 16'hFFFD
`define CIS_PAGE0 8'h00

`endif

// ---- rtl/cis_pkg.sv ----
// types for the cpu instruction subset core
package cis_pkg;
    typedef enum logic [1:0] {
        K_NOP = 2'b00, K_SUB = 2'b01, K_TZN = 2'b10, K_OTHER = 2'b11
    } cis_group_t;
    typedef enum logic [2:0] {
        K_NONE = 3'b000, K_SOFTINT = 3'b001, K_A2X = 3'b010, K_X2A = 3'b011, K_WAIT = 3'b100
    } cis_ctl_t;
    typedef enum logic [2:0] {
        MODE_REG_A = 3'b000, MODE_IMMED = 3'b001, MODE_DIR = 3'b010, MODE_LONG = 3'b011,
        MODE_OFF16 = 3'b100, MODE_OFF8 = 3'b101, MODE_IX = 3'b110, MODE_REG_X = 3'b111
    } cis_mode_t;
    typedef enum logic {ST_RUN = 1'b0, ST_HALT = 1'b1} cis_state_t;
    typedef struct packed {
        cis_group_t grp;
        cis_ctl_t ctl;
        cis_mode_t mode;
        logic [1:0] nbytes;
        logic [3:0] total;
    } cis_dec_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } cis_mem_req_t;
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] sp;
        logic [7:0] a;
        logic [7:0] x;
        logic [7:0] flags;
    } cis_regs_t;
endpackage : cis_pkg

// ---- rtl/cis_core.sv ----
// cpu core executing the subtract, test, transfer, software interrupt and wait subset
`timescale 1ns/1ps
`default_nettype none
`include "cis_defines.svh"

module cis_core (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    input wire logic WAKE_I,
    input wire logic [7:0] MEM_RDATA_I,
    output var cis_pkg::cis_mem_req_t MEM_REQ_O,
    output var cis_pkg::cis_regs_t REGS_O,
    output var logic HALT_O
);
    import cis_pkg::*;

    logic rst_meta_reg, rst_n_reg, wake_meta_reg, wake_sync_reg;
    cis_state_t state_reg;
    logic [3:0] cyc_reg;
    logic [7:0] op_reg, a_reg, x_reg, sp_reg, flags_reg;
    logic [15:0] pc_reg, ea_reg, eff_addr;
    logic [7:0] m_val;
    logic [8:0] diff;
    logic fetch, last, opnd;
    cis_dec_t dec;

    function automatic cis_dec_t decode(input logic [7:0] op);
        cis_dec_t d;
        d = '{K_NOP, K_NONE, MODE_REG_A, 2'd0, `CIS_CYC_NOP};
        case (op)
            `CIS_OP_SUB_IMMED: d = '{K_SUB, K_NONE, MODE_IMMED, 2'd1, `CIS_CYC_SUB_IMMED};
            `CIS_OP_SUB_DIR: d = '{K_SUB, K_NONE, MODE_DIR, 2'd1, `CIS_CYC_SUB_DIR};
            `CIS_OP_SUB_LONG: d = '{K_SUB, K_NONE, MODE_LONG, 2'd2, `CIS_CYC_SUB_LONG};
            `CIS_OP_SUB_OFF16: d = '{K_SUB, K_NONE, MODE_OFF16, 2'd2, `CIS_CYC_SUB_OFF16};
            `CIS_OP_SUB_OFF8: d = '{K_SUB, K_NONE, MODE_OFF8, 2'd1, `CIS_CYC_SUB_OFF8};
            `CIS_OP_SUB_IX: d = '{K_SUB, K_NONE, MODE_IX, 2'd0, `CIS_CYC_SUB_IX};
            `CIS_OP_TZN_DIR: d = '{K_TZN, K_NONE, MODE_DIR, 2'd1, `CIS_CYC_TZN_DIR};
            `CIS_OP_TZN_A: d = '{K_TZN, K_NONE, MODE_REG_A, 2'd0, `CIS_CYC_TZN_REG};
            `CIS_OP_TZN_X: d = '{K_TZN, K_NONE, MODE_REG_X, 2'd0, `CIS_CYC_TZN_REG};
            `CIS_OP_TZN_OFF8: d = '{K_TZN, K_NONE, MODE_OFF8, 2'd1, `CIS_CYC_TZN_OFF8};
            `CIS_OP_TZN_IX: d = '{K_TZN, K_NONE, MODE_IX, 2'd0, `CIS_CYC_TZN_IX};
            `CIS_OP_SOFTINT: d = '{K_OTHER, K_SOFTINT, MODE_REG_A, 2'd0, `CIS_CYC_SOFTINT};
            `CIS_OP_A2X: d = '{K_OTHER, K_A2X, MODE_REG_A, 2'd0, `CIS_CYC_XFER};
            `CIS_OP_X2A: d = '{K_OTHER, K_X2A, MODE_REG_A, 2'd0, `CIS_CYC_XFER};
            `CIS_OP_WAIT: d = '{K_OTHER, K_WAIT, MODE_REG_A, 2'd0, `CIS_CYC_WAIT};
            default: d = '{K_NOP, K_NONE, MODE_REG_A, 2'd0, `CIS_CYC_NOP};
        endcase
        return d;
    endfunction : decode

    // reset released through two flops, asserted at once
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
        end else if (CE_I) begin
            wake_meta_reg <= WAKE_I;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    assign dec = decode(op_reg);
    assign fetch = (state_reg == ST_RUN) && (cyc_reg == `CIS_STEP_FETCH);
    // padding cycles sit between the operand bytes and the last cycle
    assign last = (state_reg == ST_RUN) && (cyc_reg != `CIS_STEP_FETCH)
        && (cyc_reg == dec.total - `CIS_STEP_OPND1);
    assign opnd = (state_reg == ST_RUN) && (cyc_reg != `CIS_STEP_FETCH)
        && (cyc_reg <= {2'b00, dec.nbytes}) && (dec.mode != MODE_IMMED);

    always_comb begin
        case (dec.mode)
            MODE_OFF16, MODE_OFF8: eff_addr = ea_reg + {`CIS_PAGE0, x_reg};
            MODE_IX: eff_addr = {`CIS_PAGE0, x_reg};
            default: eff_addr = ea_reg;
        endcase
        case (dec.mode)
            MODE_REG_A: m_val = a_reg;
            MODE_REG_X: m_val = x_reg;
            default: m_val = MEM_RDATA_I;
        endcase
        diff = {1'b0, a_reg} - {1'b0, m_val};
    end

    always_comb begin
        MEM_REQ_O = '0;
        if (fetch) begin
            MEM_REQ_O.addr = pc_reg;
            MEM_REQ_O.rd = 1'b1;
        end else if (state_reg == ST_RUN && dec.grp != K_NOP && dec.grp != K_OTHER) begin
            if (opnd || (last && dec.mode == MODE_IMMED)) begin
                MEM_REQ_O.addr = pc_reg;
                MEM_REQ_O.rd = 1'b1;
            end else if (last && dec.mode != MODE_REG_A && dec.mode != MODE_REG_X) begin
                MEM_REQ_O.addr = eff_addr;
                MEM_REQ_O.rd = 1'b1;
            end
        end else if (state_reg == ST_RUN && dec.ctl == K_SOFTINT) begin
            MEM_REQ_O.addr = {`CIS_PAGE0, sp_reg};
            case (cyc_reg)
                `CIS_SOFTINT_PUSH_PCL: MEM_REQ_O.wdata = pc_reg[7:0];
                `CIS_SOFTINT_PUSH_PCH: MEM_REQ_O.wdata = pc_reg[15:8];
                `CIS_SOFTINT_PUSH_X: MEM_REQ_O.wdata = x_reg;
                `CIS_SOFTINT_PUSH_A: MEM_REQ_O.wdata = a_reg;
                default: MEM_REQ_O.wdata = flags_reg;
            endcase
            MEM_REQ_O.wr = (cyc_reg >= `CIS_SOFTINT_PUSH_PCL)
                && (cyc_reg <= `CIS_SOFTINT_PUSH_FLAGS);
            if (cyc_reg == `CIS_SOFTINT_VEC_HI) begin
                MEM_REQ_O.addr = `CIS_SOFTINT_VEC;
                MEM_REQ_O.rd = 1'b1;
            end else if (cyc_reg == `CIS_SOFTINT_VEC_LO) begin
                MEM_REQ_O.addr = `CIS_SOFTINT_VEC_LOW;
                MEM_REQ_O.rd = 1'b1;
            end else if (!MEM_REQ_O.wr) begin
                MEM_REQ_O.addr = '0;
            end
        end
    end

    // sequencing; wait leaves the halt only on the synced wake level
    always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_RUN;
            cyc_reg <= `CIS_STEP_FETCH;
            op_reg <= `CIS_OP_A2X;
        end else if (CE_I) begin
            if (state_reg == ST_HALT) begin
                if (wake_sync_reg) state_reg <= ST_RUN;
            end else begin
                if (fetch) op_reg <= MEM_RDATA_I;
                cyc_reg <= last ? `CIS_STEP_FETCH : cyc_reg + `CIS_STEP_OPND1;
                if (last && dec.ctl == K_WAIT) state_reg <= ST_HALT;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pc_reg <= `CIS_PC_RST;
        end else if (CE_I) begin
            if (fetch || opnd || (last && dec.mode == MODE_IMMED && dec.grp == K_SUB)) begin
                pc_reg <= pc_reg + 16'h0001;
            end else if (dec.ctl == K_SOFTINT && cyc_reg == `CIS_SOFTINT_VEC_LO) begin
                pc_reg <= {ea_reg[15:8], MEM_RDATA_I};
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ea_reg <= '0;
        end else if (CE_I) begin
            if (opnd && cyc_reg == `CIS_STEP_OPND1) begin
                ea_reg <= (dec.nbytes == 2'd2) ? {MEM_RDATA_I, `CIS_PAGE0}
                    : {`CIS_PAGE0, MEM_RDATA_I};
            end else if (opnd) begin
                ea_reg[7:0] <= MEM_RDATA_I;
            end else if (dec.ctl == K_SOFTINT && cyc_reg == `CIS_SOFTINT_VEC_HI) begin
                ea_reg[15:8] <= MEM_RDATA_I;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            a_reg <= '0;
            x_reg <= '0;
        end else if (CE_I && last) begin
            if (dec.grp == K_SUB) a_reg <= diff[7:0];
            if (dec.ctl == K_X2A) a_reg <= x_reg;
            if (dec.ctl == K_A2X) x_reg <= a_reg;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sp_reg <= `CIS_SP_RST;
        end else if (CE_I && MEM_REQ_O.wr) begin
            sp_reg <= sp_reg - 8'h01;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            flags_reg <= `CIS_FLAG_RST;
        end else if (CE_I) begin
            if (last && (dec.grp == K_SUB || dec.grp == K_TZN)) begin
                flags_reg[`CIS_FLAG_N] <= (dec.grp == K_SUB) ? diff[7] : m_val[7];
                flags_reg[`CIS_FLAG_Z] <= (dec.grp == K_SUB) ? (diff[7:0] == '0)
                    : (m_val == '0);
                if (dec.grp == K_SUB) flags_reg[`CIS_FLAG_C] <= diff[8];
            end
            if (state_reg == ST_RUN && dec.ctl == K_SOFTINT && cyc_reg == `CIS_SOFTINT_MASK)
                flags_reg[`CIS_FLAG_I] <= 1'b1;
            if (last && dec.ctl == K_WAIT) flags_reg[`CIS_FLAG_I] <= 1'b0;
        end
    end

    assign REGS_O = '{pc_reg, sp_reg, a_reg, x_reg, flags_reg};
    assign HALT_O = (state_reg == ST_HALT);

    // checks; a frozen clock enable voids any check in flight
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!rst_n_reg || !CE_I);

    sequence s_softint_fetch;
        fetch && MEM_RDATA_I == `CIS_OP_SOFTINT;
    endsequence
    sequence s_softint_push;
        MEM_REQ_O.wr && MEM_REQ_O.wdata == pc_reg[7:0]
        ##1 MEM_REQ_O.wr && MEM_REQ_O.wdata == pc_reg[15:8]
        ##1 MEM_REQ_O.wr && MEM_REQ_O.wdata == x_reg
        ##1 MEM_REQ_O.wr && MEM_REQ_O.wdata == a_reg
        ##1 MEM_REQ_O.wr && MEM_REQ_O.wdata == flags_reg;
    endsequence

    property p_sub_result;
        last && dec.grp == K_SUB |=> a_reg == $past(a_reg) - $past(m_val);
    endproperty
    a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");
    property p_sub_imm_len;
        fetch && MEM_RDATA_I == `CIS_OP_SUB_IMMED |=> !fetch ##1 fetch;
    endproperty
    a_sub_imm_len: assert property (p_sub_imm_len) else $error("subtract length wrong");
    property p_softint_stack;
        s_softint_fetch |-> ##2 s_softint_push ##4 fetch;
    endproperty
    a_softint_stack: assert property (p_softint_stack) else $error("stacking wrong");
    property p_softint_vec;
        s_softint_fetch |-> ##8 (MEM_REQ_O.addr == `CIS_SOFTINT_VEC && flags_reg[`CIS_FLAG_I])
            ##1 MEM_REQ_O.addr == `CIS_SOFTINT_VEC_LOW;
    endproperty
    a_softint_vec: assert property (p_softint_vec) else $error("vector fetch wrong");
    property p_a2x;
        fetch && MEM_RDATA_I == `CIS_OP_A2X |=> ##1 (x_reg == $past(a_reg) && fetch);
    endproperty
    a_a2x: assert property (p_a2x) else $error("acc_to_index wrong");
    property p_x2a;
        fetch && MEM_RDATA_I == `CIS_OP_X2A |=> ##1 (a_reg == $past(x_reg) && fetch);
    endproperty
    a_x2a: assert property (p_x2a) else $error("index_to_acc wrong");
    property p_tzn;
        last && dec.grp == K_TZN |=> flags_reg[`CIS_FLAG_Z] == ($past(m_val) == '0)
            && $stable(a_reg) && $stable(x_reg) && !$past(MEM_REQ_O.wr);
    endproperty
    a_tzn: assert property (p_tzn) else $error("test_zero_neg wrong");
    property p_wait;
        fetch && MEM_RDATA_I == `CIS_OP_WAIT |=> ##1 (HALT_O && !flags_reg[`CIS_FLAG_I]
            && flags_reg[2:0] == $past(flags_reg[2:0], 2));
    endproperty
    a_wait: assert property (p_wait) else $error("wait wrong");
    property p_long_addr;
        state_reg == ST_RUN && op_reg == `CIS_OP_SUB_LONG && cyc_reg == 4'd3
            |-> MEM_REQ_O.addr == {$past(MEM_RDATA_I, 2), $past(MEM_RDATA_I)};
    endproperty
    a_long_addr: assert property (p_long_addr) else $error("extended address wrong");
    property p_off16;
        state_reg == ST_RUN && op_reg == `CIS_OP_SUB_OFF16 && cyc_reg == 4'd4
            |-> MEM_REQ_O.addr == {$past(MEM_RDATA_I, 3), $past(MEM_RDATA_I, 2)} + x_reg;
    endproperty
    a_off16: assert property (p_off16) else $error("16-bit indexed address wrong");
    property p_off8;
        state_reg == ST_RUN && op_reg == `CIS_OP_SUB_OFF8 && cyc_reg == 4'd3
            |-> MEM_REQ_O.addr == {8'h00, $past(MEM_RDATA_I, 2)} + x_reg;
    endproperty
    a_off8: assert property (p_off8) else $error("8-bit indexed address wrong");
    property p_borrow;
        last && dec.grp == K_SUB |=> flags_reg[`CIS_FLAG_C] == ($past(a_reg) < $past(m_val));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow flag wrong");
endmodule : cis_core
`default_nettype wire

// ---- verif/test_cpu_instruction_subset.sv ----
// self-checking bench for the instruction subset core
`timescale 1ns/1ps
`default_nettype none
`include "cis_defines.svh"

module test_cpu_instruction_subset;
    import cis_pkg::*;
    localparam logic [7:0] sub_op [6] = '{`CIS_OP_SUB_IMMED, `CIS_OP_SUB_DIR,
        `CIS_OP_SUB_LONG, `CIS_OP_SUB_OFF16, `CIS_OP_SUB_OFF8, `CIS_OP_SUB_IX};
    localparam int sub_len [6] = '{2, 2, 3, 3, 2, 1};
    localparam int sub_cyc [6] = '{2, 3, 4, 5, 4, 3};
    localparam logic [7:0] tzn_op [5] = '{`CIS_OP_TZN_DIR, `CIS_OP_TZN_A, `CIS_OP_TZN_X,
        `CIS_OP_TZN_OFF8, `CIS_OP_TZN_IX};
    localparam int tzn_len [5] = '{2, 1, 1, 2, 1};
    localparam int tzn_cyc [5] = '{4, 3, 3, 5, 4};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic wake = 1'b0;
    logic [7:0] rdata;
    logic [7:0] junk = 8'h5a;
    cis_mem_req_t req;
    cis_regs_t regs;
    logic halt;
    logic [7:0] mem [0:65535];
    logic [23:0] exp_q [$];
    logic [15:0] epc;
    logic [7:0] esp, ea, ex, eflg;
    int error_cnt = 0;
    int total_checks = 0;

    always #50 clk = ~clk;
    // idle read cycles see a moving pattern, never stale data
    always @(posedge clk) junk <= ~junk + 8'h01;
    assign rdata = req.rd ? mem[req.addr] : junk;

    cis_core cis_core_i (.CORE_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .WAKE_I(wake),
        .MEM_RDATA_I(rdata), .MEM_REQ_O(req), .REGS_O(regs), .HALT_O(halt));

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // write watcher: oldest noted push against each committed write
    always @(negedge clk) begin
        #1;
        if (ce === 1'b1 && req.wr === 1'b1) begin
            if (exp_q.size() > 0) begin
                check({24'h0, req.addr, req.wdata}, {24'h0, exp_q.pop_front()});
            end else begin
                check(48'h1, 48'h0);
            end
            mem[req.addr] = req.wdata;
        end
    end

    function automatic logic [7:0] flags(input logic [7:0] c, input logic [7:0] r);
        flags = c;
        flags[`CIS_FLAG_N] = r[7];
        flags[`CIS_FLAG_Z] = (r == 8'h00);
    endfunction : flags

    task automatic chk_regs();
        check(regs, {epc, esp, ea, ex, eflg});
    endtask : chk_regs

    // cycles with ce high until the fetch at nxt shows
    task automatic wait_fetch(input logic [15:0] nxt, input bit stall, output int n);
        int k;
        n = 0;
        for (k = 0; k < 200; k++) begin
            if (req.rd === 1'b1 && req.addr === nxt) break;
            ce = stall ? 1'($urandom % 2) : 1'b1;
            @(negedge clk);
            n += int'(ce);
        end
        ce = 1'b1;
        if (k == 200) begin
            error_cnt++;
            stop_test();
        end
    endtask : wait_fetch

    task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
        input int cyc, input logic [15:0] nxt, input bit stall);
        int n;
        mem[epc] = op;
        mem[epc + 16'd1] = b1;
        mem[epc + 16'd2] = b2;
        wait_fetch(nxt, stall, n);
        check(48'(n), 48'(cyc));
        epc = nxt;
    endtask : run

    task automatic do_sub(input int md, input logic [7:0] m);
        logic [7:0] b1, b2, r;
        logic [15:0] adr;
        b1 = 8'($urandom);
        b2 = 8'($urandom);
        case (md)
            1: begin b1 = 8'h10 + 8'($urandom % 96); adr = {8'h00, b1}; end
            2: begin b1 = 8'h40 + 8'($urandom % 64); adr = {b1, b2}; end
            3: begin b1 = 8'h20 + 8'($urandom % 32); adr = {b1, b2} + {8'h00, ex}; end
            4: begin b1 = 8'($urandom % (256 - int'(ex))); adr = {8'h00, ex} + {8'h00, b1}; end
            5: adr = {8'h00, ex};
            default: begin b1 = m; adr = epc + 16'd1; end
        endcase
        mem[adr] = m;
        r = ea - m;
        run(sub_op[md], b1, b2, sub_cyc[md], epc + 16'(sub_len[md]), 1'b0);
        eflg = flags(eflg, r);
        eflg[`CIS_FLAG_C] = (ea < m);
        ea = r;
        chk_regs();
    endtask : do_sub

    task automatic do_tzn(input int md, input logic [7:0] v);
        logic [7:0] b1;
        b1 = (md == 3) ? 8'($urandom % (256 - int'(ex))) : 8'h10 + 8'($urandom % 96);
        case (md)
            0: mem[{8'h00, b1}] = v;
            1: v = ea;
            2: v = ex;
            3: mem[{8'h00, ex} + {8'h00, b1}] = v;
            default: mem[{8'h00, ex}] = v;
        endcase
        run(tzn_op[md], b1, 8'h00, tzn_cyc[md], epc + 16'(tzn_len[md]), 1'b1);
        eflg = flags(eflg, v);
        chk_regs();
    endtask : do_tzn

    initial begin
        int i, j, n;
        logic [15:0] p;
        logic [7:0] tv [3];
        void'($urandom(28));
        for (i = 0; i < 65536; i++) mem[i] = 8'h9d;
        {epc, esp, ea, ex, eflg} = {`CIS_PC_RST, `CIS_SP_RST, 16'h0000, `CIS_FLAG_RST};
        repeat (6) @(negedge clk);
        chk_regs();
        check({47'h0, halt}, 48'h0);
        rstn = 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        do_sub(0, 8'($urandom));
        run(`CIS_OP_A2X, 8'h00, 8'h00, 2, epc + 16'd1, 1'b0);
        ex = ea;
        chk_regs();
        for (i = 0; i < 6; i++) do_sub(i, 8'($urandom));
        do_sub(0, ea);
        do_tzn(1, 8'h00);
        do_sub(1, 8'h01);
        tv = '{8'h00, 8'h80, 8'($urandom)};
        for (i = 0; i < 5; i++) begin
            for (j = 0; j < 3; j++) do_tzn(i, tv[j]);
        end
        do_sub(0, 8'($urandom));
        run(`CIS_OP_X2A, 8'h00, 8'h00, 2, epc + 16'd1, 1'b0);
        ea = ex;
        chk_regs();
        // unknown opcode is a two-cycle no-op
        run(8'h9d, 8'h00, 8'h00, 2, epc + 16'd1, 1'b0);
        chk_regs();
        mem[`CIS_SOFTINT_VEC] = 8'h01;
        mem[`CIS_SOFTINT_VEC_LOW] = 8'h80;
        p = epc + 16'd1;
        exp_q.push_back({8'h00, esp, p[7:0]});
        exp_q.push_back({8'h00, esp - 8'd1, p[15:8]});
        exp_q.push_back({8'h00, esp - 8'd2, ex});
        exp_q.push_back({8'h00, esp - 8'd3, ea});
        exp_q.push_back({8'h00, esp - 8'd4, eflg});
        run(`CIS_OP_SOFTINT, 8'h00, 8'h00, 10, 16'h0180, 1'b1);
        esp = esp - 8'd5;
        eflg[`CIS_FLAG_I] = 1'b1;
        chk_regs();
        check(48'(exp_q.size()), 48'h0);
        mem[epc] = `CIS_OP_WAIT;
        n = 0;
        for (i = 0; i < 20 && halt !== 1'b1; i++) begin
            @(negedge clk);
            n++;
        end
        check(48'(n), 48'd2);
        epc = epc + 16'd1;
        eflg[`CIS_FLAG_I] = 1'b0;
        chk_regs();
        repeat (4) begin
            @(negedge clk);
            check({46'h0, req.rd, req.wr}, 48'h0);
        end
        wake = 1'b1;
        wait_fetch(epc, 1'b0, n);
        wake = 1'b0;
        check({47'h0, halt}, 48'h0);
        stop_test();
    end
endmodule : test_cpu_instruction_subset
`default_nettype wire
